// ==== palette_defines.vh ====
// Purpose: shared constants for the packed pixel palette lookup
// Assumes: Wishbone classic register bus, 32-bit data, byte address = 4 * index
// Notes: definitions only
`ifndef PALETTE_DEFINES_VH
`define PALETTE_DEFINES_VH

`define IDX_PAL_INDEX 8'h15
`define IDX_PAL_DATA 8'h17
`define IDX_CTRL 8'h18
`define IDX_STATUS 8'h19
`define ADR_IDX_MSB 9
`define ADR_IDX_LSB 2
`define COMP_MSB 7
`define COMP_LSB 4
`define SEL_DATA_BYTE 0

`define DEPTH_1BPP 2'h0
`define DEPTH_2BPP 2'h1
`define DEPTH_4BPP 2'h2
`define DEPTH_8BPP 2'h3

`define CTRL_DEPTH_LSB 0
`define CTRL_DEPTH_MSB 1
`define CTRL_MONO_BIT 2

`define COMP_RED 2'h0
`define COMP_GREEN 2'h1
`define COMP_BLUE 2'h2

`define PAL_ENTRIES 256
`define FIFO_DEPTH 8
`define FIFO_AW 3

`endif

// ==== pixel_fifo.v ====
// Purpose: small flip-flop FIFO in the display byte path
// Assumes: single clock, valid/ready on both sides
// Notes: no bypass, so one cycle of latency
`default_nettype none
module pixel_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Fill side
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    // Drain side
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    assign in_ready_out = (cnt_q != DEPTH[AW:0]);
    assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
    assign out_data_out = mem_q[rd_q];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always @(posedge clk_in)
    begin
        if (push)
            mem_q[wr_q] <= in_data_in;
    end

    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule // pixel_fifo
`default_nettype wire

// ==== packed_pixel_palette_lookup.v ====
// Purpose: unpack display bytes into pixels and look them up in a colour palette
// Assumes: one clock (pixel clock), Wishbone classic register slave
// Notes: palette has separate host and display read ports
`default_nettype none
`include "palette_defines.vh"

// Overview of operation
// [RULE1] The leftmost pixel of each byte comes from its top bits, then lower bits, then the next byte.
// [RULE2] At 1 bpp a byte gives eight pixels, bit 7 first and bit 0 last.
// [RULE3] At 2 bpp a byte gives four pixels, the first from bits 7:6 with bit 7 as its high bit.
// [RULE4] At 4 bpp the left pixel is the upper nibble and the right pixel the lower nibble.
// [RULE5] At 8 bpp on a colour panel the whole byte is the palette index.
// [RULE6] Depth limits the used index range to 2, 4, 16 or 256 entries.
// [RULE7] Colour panels get the red, green and blue of the selected entry.
// [RULE8] Monochrome panels get only the green component of the selected entry as gray.
// [RULE9] Eight bits per pixel is not available with a monochrome panel.
// [RULE10] The palette holds 256 entries of three 4-bit components.
// [RULE11] The host reaches the palette through an index register and a data register.
// [RULE12] Data accesses after setting the index reach red, then green, then blue.
// [RULE13] Below 8 bpp the host changes one pixel by read, mask, set and write back.
// [RULE14] Software forms component values from the top four bits of wider intensities.
// [RULE15] After the blue access the index steps by one and the next access is red.
// [RULE16] The data register carries the component in bits 7:4, the low bits unused.
// [RULE17] The display reads the palette on its own port every clock during host updates.
module packed_pixel_palette_lookup (
    // Clock and reset
    input wire clk_in,
    input wire nrst_in,
    // Wishbone slave
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [9:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output wire wb_ack_out,
    // Display memory byte stream
    input wire byte_valid_in,
    output wire byte_ready_out,
    input wire [7:0] byte_data_in,
    // Panel pixel stream
    output reg pix_valid_out,
    input wire pix_ready_in,
    output reg [3:0] pix_red_out,
    output reg [3:0] pix_green_out,
    output reg [3:0] pix_blue_out,
    output reg [3:0] pix_gray_out
);
    reg rst_s1_q;
    reg rst_s2_q;
    wire rst_n;

    reg [3:0] red_q [0:`PAL_ENTRIES-1];
    reg [3:0] green_q [0:`PAL_ENTRIES-1];
    reg [3:0] blue_q [0:`PAL_ENTRIES-1];

    reg [7:0] index_q;
    reg [1:0] comp_q;
    reg [2:0] ctrl_q;
    reg ack_q;

    wire [1:0] depth;
    wire mono;
    wire [1:0] eff_depth;
    wire req;
    wire [7:0] reg_idx;
    wire hit_index;
    wire hit_data;
    wire hit_ctrl;
    wire hit_status;
    wire data_acc;
    wire wr_req;
    wire wr_index;
    wire wr_ctrl;
    wire [3:0] status_word;

    wire f_valid;
    wire [7:0] f_data;
    reg f_ready;

    reg [7:0] shift_q;
    reg [2:0] left_q;
    reg have_q;
    reg [2:0] left_d;
    wire [7:0] pix_index;
    wire take;
    wire stall;
    wire [3:0] look_red;
    wire [3:0] look_green;
    wire [3:0] look_blue;

    // Reset release through two flops
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // Pixels per byte minus one for a depth
    function [2:0] last_pixel;
        input [1:0] d;
        begin
            case (d)
                `DEPTH_1BPP: last_pixel = 3'h7;
                `DEPTH_2BPP: last_pixel = 3'h3;
                `DEPTH_4BPP: last_pixel = 3'h1;
                default: last_pixel = 3'h0;
            endcase
        end
    endfunction

    // Top bits of the shift register as an index, zero-extended
    function [7:0] top_index;
        input [1:0] d;
        input [7:0] b;
        begin
            case (d)
                `DEPTH_1BPP: top_index = {7'h00, b[7]};
                `DEPTH_2BPP: top_index = {6'h00, b[7:6]};
                `DEPTH_4BPP: top_index = {4'h0, b[7:4]};
                default: top_index = b;
            endcase
        end
    endfunction

    assign depth = ctrl_q[`CTRL_DEPTH_MSB:`CTRL_DEPTH_LSB];
    assign mono = ctrl_q[`CTRL_MONO_BIT];
    // Monochrome with 8 bpp requested falls back to 4 bpp
    assign eff_depth = (mono && depth == `DEPTH_8BPP) ? `DEPTH_4BPP : depth; // [RULE9]

    // Register decode, byte address = 4 * index
    assign req = wb_cyc_in && wb_stb_in;
    assign reg_idx = wb_adr_in[`ADR_IDX_MSB:`ADR_IDX_LSB];
    assign hit_index = (reg_idx == `IDX_PAL_INDEX);
    assign hit_data = (reg_idx == `IDX_PAL_DATA);
    assign hit_ctrl = (reg_idx == `IDX_CTRL);
    assign hit_status = (reg_idx == `IDX_STATUS);
    // One access per bus cycle: counted on the ack edge only
    assign data_acc = req && ack_q && hit_data;
    assign wb_ack_out = ack_q;
    // Writes land on the ack edge, in step with the component counter
    assign wr_req = req && ack_q && wb_we_in && wb_sel_in[`SEL_DATA_BYTE];
    assign wr_index = wr_req && hit_index;
    assign wr_ctrl = wr_req && hit_ctrl;
    assign status_word = {have_q, f_valid, eff_depth};

    always @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
            index_q <= 8'h00;
            comp_q <= `COMP_RED;
            ctrl_q <= 3'h0;
            wb_dat_out <= 32'h00000000;
        end
        else
        begin
            ack_q <= req && !ack_q;
            if (req && !ack_q)
            begin
                wb_dat_out <= 32'h00000000;
                if (hit_index)
                    wb_dat_out[7:0] <= index_q;
                else if (hit_data)
                begin
                    case (comp_q)
                        `COMP_RED: wb_dat_out[`COMP_MSB:`COMP_LSB] <= red_q[index_q]; // [RULE16]
                        `COMP_GREEN: wb_dat_out[`COMP_MSB:`COMP_LSB] <= green_q[index_q];
                        default: wb_dat_out[`COMP_MSB:`COMP_LSB] <= blue_q[index_q];
                    endcase
                end
                else if (hit_ctrl)
                    wb_dat_out[2:0] <= ctrl_q;
                else if (hit_status)
                    wb_dat_out[3:0] <= status_word;
            end
            if (wr_index)
            begin
                index_q <= wb_dat_in[7:0]; // [RULE11]
                comp_q <= `COMP_RED; // [RULE12]
            end
            else if (data_acc)
            begin
                if (comp_q == `COMP_BLUE)
                begin
                    comp_q <= `COMP_RED;
                    index_q <= index_q + 8'h01; // [RULE15]
                end
                else
                    comp_q <= comp_q + 2'h1; // [RULE12]
            end
            if (wr_ctrl)
                ctrl_q <= wb_dat_in[2:0];
        end
    end

    // Host write port of the palette
    // No reset on the palette: entries stay undefined until written
    always @(posedge clk_in)
    begin
        if (wr_req && hit_data)
        begin
            case (comp_q)
                `COMP_RED: red_q[index_q] <= wb_dat_in[`COMP_MSB:`COMP_LSB]; // [RULE10] [RULE16]
                `COMP_GREEN: green_q[index_q] <= wb_dat_in[`COMP_MSB:`COMP_LSB];
                default: blue_q[index_q] <= wb_dat_in[`COMP_MSB:`COMP_LSB];
            endcase
        end
    end

    // Buffer lets display memory run ahead while the panel holds off
    pixel_fifo #(
        .WIDTH(8),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .in_valid_in(byte_valid_in),
        .in_ready_out(byte_ready_out),
        .in_data_in(byte_data_in),
        .out_valid_out(f_valid),
        .out_ready_in(f_ready),
        .out_data_out(f_data)
    );

    // Unpacker: output register stalls when the panel holds off
    assign stall = pix_valid_out && !pix_ready_in;
    assign take = have_q && !stall;
    assign pix_index = top_index(eff_depth, shift_q); // [RULE5] [RULE6]
    // Own read port, apart from the host port, so updates never stall pixels
    assign look_red = red_q[pix_index]; // [RULE17]
    assign look_green = green_q[pix_index]; // [RULE17]
    assign look_blue = blue_q[pix_index]; // [RULE17]

    always @*
    begin
        f_ready = 1'b0;
        left_d = left_q;
        if (!have_q || (take && left_q == 3'h0))
            f_ready = 1'b1;
        if (take)
            left_d = left_q - 3'h1;
    end

    always @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_q <= 8'h00;
            left_q <= 3'h0;
            have_q <= 1'b0;
            pix_valid_out <= 1'b0;
            pix_red_out <= 4'h0;
            pix_green_out <= 4'h0;
            pix_blue_out <= 4'h0;
            pix_gray_out <= 4'h0;
        end
        else
        begin
            if (f_ready && f_valid)
            begin
                shift_q <= f_data; // [RULE1]
                left_q <= last_pixel(eff_depth); // [RULE2] [RULE3] [RULE4]
                have_q <= 1'b1;
            end
            else if (take)
            begin
                left_q <= left_d;
                if (left_q == 3'h0)
                    have_q <= 1'b0;
                case (eff_depth)
                    `DEPTH_1BPP: shift_q <= {shift_q[6:0], 1'b0}; // [RULE2]
                    `DEPTH_2BPP: shift_q <= {shift_q[5:0], 2'h0}; // [RULE3]
                    // At 8 bpp this shift is harmless: the byte is already spent
                    default: shift_q <= {shift_q[3:0], 4'h0}; // [RULE4]
                endcase
            end
            if (!stall)
                pix_valid_out <= take;
            // Separate display read port, never blocked by host access
            if (take)
            begin
                pix_red_out <= mono ? 4'h0 : look_red; // [RULE7] [RULE17]
                pix_green_out <= look_green; // [RULE7] [RULE8]
                pix_blue_out <= mono ? 4'h0 : look_blue; // [RULE7]
                pix_gray_out <= mono ? look_green : 4'h0; // [RULE8]
            end
        end
    end
endmodule // packed_pixel_palette_lookup
`default_nettype wire

// ==== palette_lookup_checker_asserts.sv ====
// Purpose: port checks for the palette lookup
// Assumes: bound into the top module
// Notes: register index is adr[9:2]
`default_nettype none
module palette_lookup_checker (
    // Bus
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [9:0] wb_adr_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    // Streams
    input wire logic byte_valid_in,
    input wire logic byte_ready_out,
    input wire logic pix_valid_out,
    input wire logic pix_ready_in,
    input wire logic [3:0] pix_red_out,
    input wire logic [3:0] pix_green_out,
    input wire logic [3:0] pix_blue_out,
    input wire logic [3:0] pix_gray_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    logic req;
    logic rd;
    logic [7:0] idx;
    assign req = wb_cyc_in && wb_stb_in;
    assign rd = wb_ack_out && !wb_we_in;
    assign idx = wb_adr_in[9:2];
    property p_ack_next;
        req && !wb_ack_out |=> wb_ack_out;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");
    property p_ack_once;
        wb_ack_out |=> !wb_ack_out;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    property p_ack_idle;
        !req |=> !wb_ack_out;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack unasked");
    property p_unmapped;
        rd && !(idx inside {8'h15, 8'h17, 8'h18, 8'h19}) |-> wb_dat_out == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_nibble;
        rd && idx == 8'h17 |-> wb_dat_out[3:0] == 4'h0 && wb_dat_out[31:8] == 24'h0;
    endproperty
    a_nibble: assert property (p_nibble) else $error("data bits");
    property p_hold;
        pix_valid_out && !pix_ready_in |=> pix_valid_out
            && $stable({pix_red_out, pix_green_out, pix_blue_out, pix_gray_out});
    endproperty
    a_hold: assert property (p_hold) else $error("pixel dropped");
    property p_mono;
        pix_valid_out && pix_gray_out != 4'h0 |-> pix_red_out == 4'h0 && pix_blue_out == 4'h0;
    endproperty
    a_mono: assert property (p_mono) else $error("mono colour");
    property p_colour;
        pix_valid_out && (pix_red_out | pix_blue_out) != 4'h0 |-> pix_gray_out == 4'h0;
    endproperty
    a_colour: assert property (p_colour) else $error("colour gray");
    // Bound of 4 covers the three-stage walk with one spare
    property p_soon;
        byte_valid_in && byte_ready_out && !pix_valid_out |-> ##[1:4] pix_valid_out;
    endproperty
    a_soon: assert property (p_soon) else $error("pixel late");
    c_write: cover property (wb_ack_out && wb_we_in);
    c_full: cover property (byte_valid_in && !byte_ready_out);
    c_stall: cover property (pix_valid_out && !pix_ready_in ##1 pix_ready_in);
endmodule // palette_lookup_checker
bind packed_pixel_palette_lookup palette_lookup_checker i_chk (.clk_in, .nrst_in, .wb_cyc_in,
    .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out, .byte_valid_in,
    .byte_ready_out, .pix_valid_out, .pix_ready_in, .pix_red_out, .pix_green_out,
    .pix_blue_out, .pix_gray_out);
`default_nettype wire

// ==== panel_sink.sv ====
// Purpose: panel side pixel sink
// Assumes: pixel taken on valid and ready
// Notes: slow mode drops ready every other cycle
`default_nettype none
module panel_sink (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic stall_in,
    input wire logic slow_in,
    input wire logic valid_in,
    input wire logic [15:0] pix_in,
    output logic ready_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] got[$];
    logic ph_q;
    assign ready_out = !stall_in && !(slow_in && ph_q);
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            ph_q <= 1'b0;
        else
        begin
            ph_q <= !ph_q;
            if (valid_in && ready_out)
                got.push_back(pix_in);
        end
    end
endmodule // panel_sink
`default_nettype wire

// ==== packed_pixel_palette_lookup_bench.sv ====
// Purpose: self-checking bench for the palette lookup
// Assumes: 25 MHz clock, classic bus master
// Notes: entries 0 to 15 and A5 are programmed
`default_nettype none
module packed_pixel_palette_lookup_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [2:0] ctl; logic [7:0] byt; int np;} row_t;
    row_t rows[8] = '{'{3'h0, 8'hB4, 8}, '{3'h1, 8'h1B, 4}, '{3'h2, 8'h5C, 2},
        '{3'h3, 8'hA5, 1}, '{3'h4, 8'h69, 8}, '{3'h5, 8'hE4, 4}, '{3'h6, 8'hF0, 2},
        '{3'h7, 8'h3C, 2}};
    logic clk_in = 0, nrst_in = 0, cyc = 0, we = 0, bv = 0, stall = 0, slow = 0;
    logic ack, brdy, pv, prdy;
    logic [9:0] adr = 0;
    logic [3:0] sel = 4'h1;
    logic [31:0] wd = 0, rd, dat_o;
    logic [7:0] bd = 0, e;
    logic [3:0] r, g, b, gy;
    int err_count = 0, n_compared = 0, s, w;
    always #20 clk_in = ~clk_in;
    packed_pixel_palette_lookup i_dut (.clk_in, .nrst_in, .wb_cyc_in(cyc), .wb_stb_in(cyc),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wd), .wb_dat_out(dat_o),
        .wb_ack_out(ack), .byte_valid_in(bv), .byte_ready_out(brdy), .byte_data_in(bd),
        .pix_valid_out(pv), .pix_ready_in(prdy), .pix_red_out(r), .pix_green_out(g),
        .pix_blue_out(b), .pix_gray_out(gy));
    panel_sink i_panel (.clk_in, .nrst_in, .stall_in(stall), .slow_in(slow), .valid_in(pv),
        .pix_in({r, g, b, gy}), .ready_out(prdy));
    function automatic logic [3:0] comp(input logic [7:0] x, input int c);
        comp = c == 0 ? x[3:0] ^ x[7:4] : c == 1 ? ~x[3:0] : x[3:0] + x[7:4] + 4'h5;
    endfunction
    // Mono keeps green on both green and gray
    function automatic logic [31:0] px(input logic [2:0] ctl, input logic [7:0] x);
        px = ctl[2] ? {20'h0, comp(x, 1), 8'h0} | comp(x, 1) : {16'h0, comp(x, 0), comp(x, 1),
            comp(x, 2), 4'h0};
    endfunction
    task automatic results();
        $display("counts %0d compared %0d bad", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic timeout();
        err_count++;
        $display("BAD wait expired");
        results();
    endtask
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] v);
        int n;
        n = 0;
        @(posedge clk_in);
        cyc <= 1'b1;
        we <= wr;
        adr <= {idx, 2'b00};
        wd <= {24'h0, v};
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        rd = dat_o;
        cyc <= 1'b0;
        if (ack !== 1'b1)
            timeout();
    endtask
    task automatic send(input logic [7:0] v);
        int n;
        n = 0;
        @(posedge clk_in);
        bv <= 1'b1;
        bd <= v;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (brdy !== 1'b1 && n < 50);
        bv <= 1'b0;
        if (brdy !== 1'b1)
            timeout();
    endtask
    task automatic wait_pix(input int np);
        int n;
        for (n = 0; i_panel.got.size() < np && n < 300; n++)
            @(posedge clk_in);
        if (i_panel.got.size() < np)
            timeout();
    endtask
    initial
    begin
        repeat (3) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk("reset", 32'h0, {30'h0, pv, ack});
        bus(8'h15, 1'b1, 8'h00);
        for (int k = 0; k < 48; k++)
            bus(8'h17, 1'b1, {comp(8'(k / 3), k % 3), 4'h0});
        bus(8'h15, 1'b1, 8'hA5);
        // Eight-bit intensities: only their top four bits may land
        for (int c = 0; c < 3; c++)
            bus(8'h17, 1'b1, {comp(8'hA5, c), 4'h9});
        bus(8'h15, 1'b1, 8'h03);
        for (int k = 0; k < 6; k++)
        begin
            bus(8'h17, 1'b0, 8'h00);
            chk("data", {24'h0, comp(8'(3 + k / 3), k % 3), 4'h0}, rd);
        end
        bus(8'h15, 1'b0, 8'h00);
        chk("index", 32'h5, rd);
        bus(8'h20, 1'b0, 8'h00);
        chk("unmapped", 32'h0, rd);
        $display("test registers done");
        foreach (rows[i])
        begin
            bus(8'h18, 1'b1, {5'h0, rows[i].ctl});
            slow <= i[0];
            send(rows[i].byt);
            wait_pix(rows[i].np);
            repeat (6) @(posedge clk_in);
            chk("count", rows[i].np, i_panel.got.size());
            w = 8 / rows[i].np;
            for (int k = 0; k < rows[i].np; k++)
            begin
                e = 8'((rows[i].byt >> (8 - w * (k + 1))) & ((1 << w) - 1));
                chk("pixel", px(rows[i].ctl, e), i_panel.got[k]);
            end
            i_panel.got.delete();
        end
        bus(8'h19, 1'b0, 8'h00);
        chk("depth", 32'h2, rd);
        bus(8'h18, 1'b0, 8'h00);
        chk("ctrl", 32'h7, rd);
        // One pixel changed by read, mask, set and write back
        bus(8'h18, 1'b1, 8'h01);
        e = (8'h1B & ~8'h30) | 8'h20;
        send(e);
        wait_pix(4);
        chk("rmw", px(3'h1, 8'h2), i_panel.got[1]);
        chk("rmw keep", px(3'h1, 8'h0), i_panel.got[0]);
        i_panel.got.delete();
        $display("test rows done");
        // Panel stalled so the buffer must fill and refuse
        bus(8'h18, 1'b1, 8'h03);
        stall <= 1'b1;
        @(posedge clk_in);
        bv <= 1'b1;
        bd <= 8'h00;
        s = 0;
        repeat (20)
        begin
            @(posedge clk_in);
            if (brdy === 1'b1)
            begin
                s++;
                bd <= 8'(s[3:0]);
            end
        end
        bv <= 1'b0;
        chk("refused", 32'h0, {31'h0, brdy});
        chk("held", 32'h1, {31'h0, s >= 8});
        stall <= 1'b0;
        wait_pix(s);
        for (int k = 0; k < s; k++)
            chk("drain", px(3'h3, 8'(k % 16)), i_panel.got[k]);
        repeat (4) @(posedge clk_in);
        chk("empty", 32'h3, {30'h0, brdy, !pv});
        $display("test buffer done");
        // Reset in mid-run: registers clear, palette keeps its contents
        nrst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk("rst out", 32'h0, {30'h0, pv, ack});
        nrst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        sel <= 4'h0;
        bus(8'h15, 1'b1, 8'h44);
        sel <= 4'h1;
        bus(8'h15, 1'b0, 8'h00);
        chk("rst index", 32'h0, rd);
        for (int c = 0; c < 2; c++)
        begin
            bus(8'h17, 1'b0, 8'h00);
            chk("rst palette", {24'h0, comp(8'h00, c), 4'h0}, rd);
        end
        $display("test reset done");
        results();
    end
endmodule // packed_pixel_palette_lookup_bench
`default_nettype wire
